// file: hdl/cgr_defines.svh
`ifndef CGR_DEFINES_SVH
`define CGR_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets and access codes.
// ----------------------------------------------------------------
`define CGR_OFS_FREQ_LOCK     7'h00
`define CGR_OFS_PCI_EN        7'h01
`define CGR_OFS_CPU_REF_USB   7'h02
`define CGR_OFS_FREE_DRIVE    7'h03
`define CGR_NUM_REGS          8'h04
`define CGR_CMD_BLOCK         8'h00
`define CGR_CMD_BYTE_BIT      7

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define CGR_B0_WDIS           7
`define CGR_B0_PCI7           5
`define CGR_B0_FS_MSB         4
`define CGR_B0_FS_LSB         1
`define CGR_B0_WEN            0
`define CGR_B3_PCI_DRIVE_STRENGTH        7
`define CGR_B3_COMBO_DRV      6

// ----------------------------------------------------------------
// Reset values; frequency select bits come from the straps.
// ----------------------------------------------------------------
`define CGR_B0_RST            8'h20
`define CGR_B1_RST            8'hff
`define CGR_B2_RST            8'hfe
`define CGR_B3_RST            8'h07

// ----------------------------------------------------------------
// Gated output channels.
// ----------------------------------------------------------------
`define CGR_NCH               19
`define CGR_CH_PCI_FREE       8
`define CGR_CH_REF_CLK_OUT_ZERO           9
`define CGR_CH_FLOPPY         12
`define CGR_CH_USB            13
`define CGR_CH_COMBO1         14
`define CGR_CH_CPU0           17

`endif

// file: hdl/cgr_pkg.sv
`default_nettype none

package cgr_pkg;

    typedef logic [7:0] cgr_byte_t;

    typedef enum logic [1:0] {
        cgr_idle  = 2'b00,
        cgr_byte  = 2'b01,
        cgr_block = 2'b10,
        cgr_none  = 2'b11
    } cgr_mode_t;

endpackage

`default_nettype wire

// file: hdl/cgr_gate_if.sv
`default_nettype none

interface cgr_gate_if #(parameter int N = 19);
    logic [N-1:0] src;
    logic [N-1:0] en;
    logic [N-1:0] out;
    logic [N-1:0] out_n;

    modport core (input src, input en, output out, output out_n);
    modport ctrl (output src, output en, input out, input out_n);
endinterface

`default_nettype wire

// file: hdl/cgr_clk_gate.sv
`default_nettype none

module cgr_clk_gate #(
    parameter int N = 19
) (
    input  wire logic    clock,
    input  wire logic    nrst,
    input  wire logic    ce,
    cgr_gate_if.core     gif
);
    import cgr_pkg::*;

    // ----------------------------------------------------------------
    // Per channel: filter the source, move the enable while it is low.
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            logic s1_q, s2_q, s3_q, lvl_q, app_q, out_q, outn_q;
            logic s1_d, s2_d, s3_d, lvl_d, app_d, out_d, outn_d;

            always_comb begin
                s1_d   = gif.src[i];
                s2_d   = s1_q;
                s3_d   = s2_q;
                lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
                app_d  = lvl_q ? app_q : gif.en[i];
                out_d  = lvl_q & app_q;
                outn_d = ~(lvl_q & app_q);
            end

            always_ff @(posedge clock) begin
                if (!nrst) begin
                    s1_q   <= 1'b0;
                    s2_q   <= 1'b0;
                    s3_q   <= 1'b0;
                    lvl_q  <= 1'b0;
                    app_q  <= 1'b0;
                    out_q  <= 1'b0;
                    outn_q <= 1'b1;
                end else if (ce) begin
                    s1_q   <= s1_d;
                    s2_q   <= s2_d;
                    s3_q   <= s3_d;
                    lvl_q  <= lvl_d;
                    app_q  <= app_d;
                    out_q  <= out_d;
                    outn_q <= outn_d;
                end
            end

            assign gif.out[i]   = out_q;
            assign gif.out_n[i] = outn_q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: hdl/cgr_regs.sv
`include "cgr_defines.svh"
`default_nettype none

module cgr_regs (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic              cmd_valid,
    input  wire cgr_pkg::cgr_byte_t cmd_byte,
    input  wire logic              wr_valid,
    input  wire cgr_pkg::cgr_byte_t wr_data,
    input  wire logic              rd_req,
    input  wire logic              txn_stop,
    input  wire logic [3:0]        fs_strap,
    input  wire logic              pci_stop_pin,
    input  wire logic [18:0]       clk_src,
    output var  cgr_pkg::cgr_byte_t rd_data,
    output var  logic              rd_valid,
    output var  logic              wr_ack,
    output var  logic              freq_sel_bit3,
    output var  logic              freq_sel_bit2,
    output var  logic              freq_sel_bit1,
    output var  logic              freq_sel_bit0,
    output var  logic              pci_drive_strength,
    output var  logic              combo_clk_drive_strength,
    output var  logic              pci_clk_out_zero,
    output var  logic              pci_clk_out_one,
    output var  logic              pci_clk_out_two,
    output var  logic              pci_clk_out_three,
    output var  logic              pci_clk_out_four,
    output var  logic              pci_clk_out_five,
    output var  logic              pci_clk_out_six,
    output var  logic              pci_clk_out_seven,
    output var  logic              pci_clk_free_out,
    output var  logic              ref_clk_out_zero,
    output var  logic              ref_clk_out_one,
    output var  logic              ref_clk_out_two,
    output var  logic              floppy_clk_out,
    output var  logic              usb_clk_out,
    output var  logic              combo_clk_out_one,
    output var  logic              combo_clk_out_two,
    output var  logic              combo_clk_out_three,
    output var  logic              cpu_true_output_zero,
    output var  logic              cpu_complement_output_zero,
    output var  logic              cpu_true_output_one,
    output var  logic              cpu_complement_output_one
);
    import cgr_pkg::*;

    // ----------------------------------------------------------------
    // Strap and stop pin synchronisers.
    // ----------------------------------------------------------------
    logic [3:0] fs1_q, fs2_q, fs3_q, fsf_q, fsf_d;
    logic       st1_q, st2_q, st3_q, stf_q, stf_d;

    always_comb begin
        fsf_d = (fs2_q == fs3_q) ? fs3_q : fsf_q;
        stf_d = (st2_q == st3_q) ? st3_q : stf_q;
    end

    always_ff @(posedge clock) begin
        if (ce) begin
            fs1_q <= fs_strap;
            fs2_q <= fs1_q;
            fs3_q <= fs2_q;
            fsf_q <= fsf_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st1_q <= 1'b0;
            st2_q <= 1'b0;
            st3_q <= 1'b0;
            stf_q <= 1'b0;
        end else if (ce) begin
            st1_q <= pci_stop_pin;
            st2_q <= st1_q;
            st3_q <= st2_q;
            stf_q <= stf_d;
        end
    end

    // ----------------------------------------------------------------
    // Register file and transaction tracking.
    // ----------------------------------------------------------------
    cgr_byte_t regs_q [4];
    cgr_byte_t regs_d [4];
    cgr_byte_t b0_rst;
    cgr_mode_t mode_q, mode_d;
    logic [6:0] idx_q, idx_d;
    cgr_byte_t cnt_q, cnt_d;
    logic       seen_q, seen_d;
    logic       unlock_q, unlock_d;
    cgr_byte_t rdat_q, rdat_d;
    logic       rval_q, rval_d;
    logic       ack_q, ack_d;
    logic       allow;
    logic       wdis;

    function automatic cgr_byte_t rd_reg(input logic [6:0] ofs);
        rd_reg = (ofs < 7'(`CGR_NUM_REGS)) ? regs_q[ofs[1:0]] : 8'h00;
    endfunction

    always_comb begin
        wdis   = regs_q[0][`CGR_B0_WDIS];
        allow  = unlock_q & ~wdis;
        b0_rst = `CGR_B0_RST;
        b0_rst[`CGR_B0_FS_MSB:`CGR_B0_FS_LSB] = fsf_q;
        regs_d   = regs_q;
        mode_d   = mode_q;
        idx_d    = idx_q;
        cnt_d    = cnt_q;
        seen_d   = seen_q;
        unlock_d = unlock_q;
        rdat_d   = rdat_q;
        rval_d   = 1'b0;
        ack_d    = 1'b0;
        if (cmd_valid) begin
            seen_d = 1'b0;
            idx_d  = 7'h00;
            if (cmd_byte[`CGR_CMD_BYTE_BIT]) begin
                mode_d = cgr_byte;
                idx_d  = cmd_byte[6:0];
            end else if (cmd_byte == `CGR_CMD_BLOCK) begin
                mode_d   = cgr_block;
                unlock_d = regs_q[0][`CGR_B0_WEN];
            end else begin
                mode_d = cgr_none;
            end
        end else if (wr_valid) begin
            ack_d = 1'b1;
            case (mode_q)
                cgr_byte, cgr_block: begin
                    if (mode_q == cgr_block && !seen_q) begin
                        cnt_d  = wr_data;
                        seen_d = 1'b1;
                    end else if ((mode_q == cgr_byte && !seen_q) ||
                                 (mode_q == cgr_block &&
                                  {1'b0, idx_q} < cnt_q)) begin
                        seen_d = 1'b1;
                        if (mode_q == cgr_block) begin
                            idx_d = idx_q + 7'h01;
                        end
                        if (idx_q < 7'(`CGR_NUM_REGS) && !wdis) begin
                            if (allow) begin
                                regs_d[idx_q[1:0]] = wr_data;
                            end else if (idx_q == `CGR_OFS_FREQ_LOCK) begin
                                regs_d[0][`CGR_B0_WEN] =
                                    wr_data[`CGR_B0_WEN];
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (rd_req) begin
            rval_d = 1'b1;
            case (mode_q)
                cgr_byte: rdat_d = rd_reg(idx_q);
                cgr_block: begin
                    if (!seen_q) begin
                        rdat_d = `CGR_NUM_REGS;
                        seen_d = 1'b1;
                    end else begin
                        rdat_d = rd_reg(idx_q);
                        idx_d  = idx_q + 7'h01;
                    end
                end
                default: rdat_d = 8'h00;
            endcase
        end else if (txn_stop) begin
            mode_d = cgr_idle;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            regs_q[0] <= b0_rst;
            regs_q[1] <= `CGR_B1_RST;
            regs_q[2] <= `CGR_B2_RST;
            regs_q[3] <= `CGR_B3_RST;
            mode_q    <= cgr_idle;
            idx_q     <= 7'h00;
            cnt_q     <= 8'h00;
            seen_q    <= 1'b0;
            unlock_q  <= 1'b0;
            rdat_q    <= 8'h00;
            rval_q    <= 1'b0;
            ack_q     <= 1'b0;
        end else if (ce) begin
            regs_q   <= regs_d;
            mode_q   <= mode_d;
            idx_q    <= idx_d;
            cnt_q    <= cnt_d;
            seen_q   <= seen_d;
            unlock_q <= unlock_d;
            rdat_q   <= rdat_d;
            rval_q   <= rval_d;
            ack_q    <= ack_d;
        end
    end

    // ----------------------------------------------------------------
    // Output enables and gating.
    // ----------------------------------------------------------------
    cgr_gate_if #(.N(`CGR_NCH)) gif ();
    logic [`CGR_NCH-1:0] en;
    logic [7:0]          pci_stop_mask;

    always_comb begin
        pci_stop_mask = {8{stf_q}} & ~{2'b00, regs_q[3][5:3], 3'b000};
        en = '0;
        en[7:0] = {regs_q[0][`CGR_B0_PCI7], regs_q[1][6:0]}
                  & ~pci_stop_mask;
        en[`CGR_CH_PCI_FREE] = regs_q[1][7];
        en[`CGR_CH_REF_CLK_OUT_ZERO+2:`CGR_CH_REF_CLK_OUT_ZERO] = regs_q[2][5:3];
        en[`CGR_CH_FLOPPY]   = regs_q[2][2];
        en[`CGR_CH_USB]      = regs_q[2][1];
        en[`CGR_CH_COMBO1+2:`CGR_CH_COMBO1] = regs_q[3][2:0];
        en[`CGR_CH_CPU0+1:`CGR_CH_CPU0] = regs_q[2][7:6];
    end

    assign gif.src = clk_src;
    assign gif.en  = en;

    cgr_clk_gate #(.N(`CGR_NCH)) u_gate (
        .clock (clock),
        .nrst  (nrst),
        .ce    (ce),
        .gif   (gif)
    );

    assign rd_data                    = rdat_q;
    assign rd_valid                   = rval_q;
    assign wr_ack                     = ack_q;
    assign freq_sel_bit3              = regs_q[0][4];
    assign freq_sel_bit2              = regs_q[0][3];
    assign freq_sel_bit1              = regs_q[0][2];
    assign freq_sel_bit0              = regs_q[0][1];
    assign pci_drive_strength         = regs_q[3][`CGR_B3_PCI_DRIVE_STRENGTH];
    assign combo_clk_drive_strength   = regs_q[3][`CGR_B3_COMBO_DRV];
    assign pci_clk_out_zero           = gif.out[0];
    assign pci_clk_out_one            = gif.out[1];
    assign pci_clk_out_two            = gif.out[2];
    assign pci_clk_out_three          = gif.out[3];
    assign pci_clk_out_four           = gif.out[4];
    assign pci_clk_out_five           = gif.out[5];
    assign pci_clk_out_six            = gif.out[6];
    assign pci_clk_out_seven          = gif.out[7];
    assign pci_clk_free_out           = gif.out[`CGR_CH_PCI_FREE];
    assign ref_clk_out_zero           = gif.out[`CGR_CH_REF_CLK_OUT_ZERO];
    assign ref_clk_out_one            = gif.out[`CGR_CH_REF_CLK_OUT_ZERO+1];
    assign ref_clk_out_two            = gif.out[`CGR_CH_REF_CLK_OUT_ZERO+2];
    assign floppy_clk_out             = gif.out[`CGR_CH_FLOPPY];
    assign usb_clk_out                = gif.out[`CGR_CH_USB];
    assign combo_clk_out_one          = gif.out[`CGR_CH_COMBO1];
    assign combo_clk_out_two          = gif.out[`CGR_CH_COMBO1+1];
    assign combo_clk_out_three        = gif.out[`CGR_CH_COMBO1+2];
    assign cpu_true_output_zero       = gif.out[`CGR_CH_CPU0];
    assign cpu_complement_output_zero = gif.out_n[`CGR_CH_CPU0];
    assign cpu_true_output_one        = gif.out[`CGR_CH_CPU0+1];
    assign cpu_complement_output_one  = gif.out_n[`CGR_CH_CPU0+1];

endmodule

`default_nettype wire

// file: verification/cgr_host_model.sv
`default_nettype none

module cgr_host_model (
    input  wire logic               clock,
    output var  logic               cmd_valid,
    output var  cgr_pkg::cgr_byte_t cmd_byte,
    output var  logic               wr_valid,
    output var  cgr_pkg::cgr_byte_t wr_data,
    output var  logic               rd_req,
    output var  logic               txn_stop,
    input  wire logic               wr_ack,
    input  wire logic               rd_valid,
    input  wire cgr_pkg::cgr_byte_t rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import cgr_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        wr_valid  = 1'b0;
        wr_data   = 8'h00;
        rd_req    = 1'b0;
        txn_stop  = 1'b0;
    end

    // Opens a transaction; the command picks byte or block access.
    task automatic start(input cgr_byte_t c);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_byte  <= c;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~c;
    endtask

    // Sends one byte; the answer is registered on the same edge that takes it.
    task automatic put(input cgr_byte_t d, output logic ok);
        @(posedge clock);
        wr_valid <= 1'b1;
        wr_data  <= d;
        @(posedge clock);
        wr_valid <= 1'b0;
        wr_data  <= ~d;
        #1;
        ok = wr_ack;
    endtask

    task automatic get(output cgr_byte_t d, output logic ok);
        @(posedge clock);
        rd_req <= 1'b1;
        @(posedge clock);
        rd_req <= 1'b0;
        #1;
        ok = rd_valid;
        d  = rd_data;
    endtask

    task automatic stop();
        @(posedge clock);
        txn_stop <= 1'b1;
        @(posedge clock);
        txn_stop <= 1'b0;
    endtask
endmodule

`default_nettype wire

// file: verification/cgr_regs_properties.sv
`default_nettype none

module cgr_regs_properties (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               cmd_valid,
    input  wire logic               wr_valid,
    input  wire logic               rd_req,
    input  wire logic               wr_ack,
    input  wire logic               rd_valid,
    input  wire cgr_pkg::cgr_byte_t rd_data,
    input  wire logic               freq_sel_bit3,
    input  wire logic               freq_sel_bit2,
    input  wire logic               freq_sel_bit1,
    input  wire logic               freq_sel_bit0,
    input  wire logic               pci_drive_strength,
    input  wire logic               combo_clk_drive_strength,
    input  wire logic               ref_clk_out_zero,
    input  wire logic               floppy_clk_out,
    input  wire logic               cpu_true_output_zero,
    input  wire logic               cpu_complement_output_zero,
    input  wire logic               cpu_true_output_one,
    input  wire logic               cpu_complement_output_one
);
    timeunit 1ns;
    timeprecision 1ps;
    import cgr_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    AST_WR_ACKED: assert property (
        ce && wr_valid && !cmd_valid |=> wr_ack)
        else $error("Data byte was not acknowledged.");
    AST_ACK_CAUSE: assert property (
        wr_ack |-> $past(wr_valid) && $past(ce))
        else $error("Acknowledge without a data byte.");
    AST_RD_ANSWER: assert property (
        ce && rd_req && !cmd_valid && !wr_valid |=> rd_valid)
        else $error("Read request got no answer.");
    AST_RD_CAUSE: assert property (
        rd_valid |-> $past(rd_req))
        else $error("Read answer without a request.");
    AST_RD_HOLD: assert property (
        !rd_valid |-> $stable(rd_data))
        else $error("Read data changed without a read.");
    AST_FS_WRITE: assert property (
        $changed({freq_sel_bit3, freq_sel_bit2, freq_sel_bit1,
                  freq_sel_bit0}) |-> wr_ack)
        else $error("Frequency select changed without a write.");
    AST_DRV_WRITE: assert property (
        $changed({pci_drive_strength, combo_clk_drive_strength})
        |-> wr_ack)
        else $error("Drive strength changed without a write.");
    AST_CPU_PAIR: assert property (
        cpu_complement_output_zero == !cpu_true_output_zero &&
        cpu_complement_output_one == !cpu_true_output_one)
        else $error("CPU pair outputs are not complementary.");
    AST_REF_NO_RUNT: assert property (
        $rose(ref_clk_out_zero) && $past(nrst, 8) |-> ref_clk_out_zero[*4])
        else $error("Truncated high pulse on reference output.");
    AST_FLOPPY_NO_RUNT: assert property (
        $fell(floppy_clk_out) && $past(nrst, 8) |-> !floppy_clk_out[*4])
        else $error("Truncated low phase on floppy output.");

    COV_WRITE: cover property (wr_ack);
    COV_READ: cover property (rd_valid);
    COV_PAIR_OFF: cover property (!cpu_true_output_zero[*8]);
endmodule

bind cgr_regs cgr_regs_properties u_props (
    .clock(clock), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid),
    .wr_valid(wr_valid), .rd_req(rd_req), .wr_ack(wr_ack),
    .rd_valid(rd_valid), .rd_data(rd_data),
    .freq_sel_bit3(freq_sel_bit3), .freq_sel_bit2(freq_sel_bit2),
    .freq_sel_bit1(freq_sel_bit1), .freq_sel_bit0(freq_sel_bit0),
    .pci_drive_strength(pci_drive_strength),
    .combo_clk_drive_strength(combo_clk_drive_strength),
    .ref_clk_out_zero(ref_clk_out_zero), .floppy_clk_out(floppy_clk_out),
    .cpu_true_output_zero(cpu_true_output_zero),
    .cpu_complement_output_zero(cpu_complement_output_zero),
    .cpu_true_output_one(cpu_true_output_one),
    .cpu_complement_output_one(cpu_complement_output_one)
);

`default_nettype wire

// file: verification/tb.sv
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, a, b); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cgr_pkg::*;

    logic        clock, nrst, ce, cmd_valid, wr_valid, rd_req, txn_stop;
    cgr_byte_t   cmd_byte, wr_data, rd_data;
    logic [3:0]  fs_strap;
    logic        pci_stop_pin, rd_valid, wr_ack;
    logic [18:0] clk_src = 19'h00000;
    logic [2:0]  phase = 3'h0;
    logic [3:0]  fsel;
    logic        freq_sel_bit3, freq_sel_bit2, freq_sel_bit1, freq_sel_bit0;
    logic        pci_drive_strength, combo_clk_drive_strength;
    logic        pci_clk_out_zero, pci_clk_free_out, ref_clk_out_two;
    logic        usb_clk_out, combo_clk_out_one;
    logic        cpu_true_output_zero, cpu_complement_output_zero;
    int          errors, samples_checked;

    assign fsel = {freq_sel_bit3, freq_sel_bit2,
                   freq_sel_bit1, freq_sel_bit0};

    cgr_regs dut (
        .clock, .nrst, .ce, .cmd_valid, .cmd_byte, .wr_valid, .wr_data,
        .rd_req, .txn_stop, .fs_strap, .pci_stop_pin, .clk_src, .rd_data,
        .rd_valid, .wr_ack, .freq_sel_bit3, .freq_sel_bit2, .freq_sel_bit1,
        .freq_sel_bit0, .pci_drive_strength, .combo_clk_drive_strength,
        .pci_clk_out_zero, .pci_clk_out_one(), .pci_clk_out_two(),
        .pci_clk_out_three(), .pci_clk_out_four(), .pci_clk_out_five(),
        .pci_clk_out_six(), .pci_clk_out_seven(), .pci_clk_free_out,
        .ref_clk_out_zero(), .ref_clk_out_one(), .ref_clk_out_two,
        .floppy_clk_out(), .usb_clk_out, .combo_clk_out_one,
        .combo_clk_out_two(), .combo_clk_out_three(), .cpu_true_output_zero,
        .cpu_complement_output_zero, .cpu_true_output_one(),
        .cpu_complement_output_one()
    );

    cgr_host_model host (
        .clock, .cmd_valid, .cmd_byte, .wr_valid, .wr_data, .rd_req,
        .txn_stop, .wr_ack, .rd_valid, .rd_data
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Slow square wave on every clock source, 8 cycles high, 8 low.
    always @(posedge clock) begin
        phase <= phase + 3'h1;
        if (phase == 3'h7)
            clk_src <= ~clk_src;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tmo(input logic ok);
        `CHK(ok, 1'b1)
        if (ok !== 1'b1)
            final_report();
    endtask

    task automatic blkw(input cgr_byte_t d[4]);
        logic ok;
        host.start(8'h00);
        host.put(8'h04, ok);
        tmo(ok);
        foreach (d[i]) begin
            host.put(d[i], ok);
            tmo(ok);
        end
        host.stop();
    endtask

    task automatic blkr(input cgr_byte_t e[4]);
        logic      ok;
        cgr_byte_t v;
        host.start(8'h00);
        host.get(v, ok);
        tmo(ok);
        `CHK(v, 8'h04)
        foreach (e[i]) begin
            host.get(v, ok);
            tmo(ok);
            `CHK(v, e[i])
        end
        host.stop();
    endtask

    task automatic bw(input cgr_byte_t c, input cgr_byte_t d);
        logic ok;
        host.start(c);
        host.put(d, ok);
        tmo(ok);
        host.stop();
    endtask

    task automatic br(input cgr_byte_t c, input cgr_byte_t e);
        logic      ok;
        cgr_byte_t v;
        host.start(c);
        host.get(v, ok);
        tmo(ok);
        `CHK(v, e)
        host.stop();
    endtask

    // Collects which outputs were seen high; complements are folded in inverted.
    task automatic look(input logic [6:0] e);
        logic [6:0] s;
        s = 7'h00;
        repeat (20) @(posedge clock);
        repeat (40) begin
            @(negedge clock);
            s = s | {pci_clk_out_zero, pci_clk_free_out, ref_clk_out_two,
                     usb_clk_out, combo_clk_out_one, cpu_true_output_zero,
                     ~cpu_complement_output_zero};
        end
        `CHK(s, e)
    endtask

    initial begin
        logic      ok;
        cgr_byte_t v;
        nrst = 1'b0;
        ce = 1'b1;
        fs_strap = 4'ha;
        pci_stop_pin = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        blkr('{8'h34, 8'hff, 8'hfe, 8'h07});
        `CHK(fsel, 4'ha)
        `CHK({pci_drive_strength, combo_clk_drive_strength}, 2'b00)
        look(7'h7f);
        @(posedge clock);
        pci_stop_pin <= 1'b1;
        look(7'h3f);
        @(posedge clock);
        pci_stop_pin <= 1'b0;
        $display("test reset values done");
        blkw('{8'h01, 8'h00, 8'h00, 8'h00});
        br(8'h80, 8'h35);
        br(8'h81, 8'hff);
        bw(8'h81, 8'h00);
        br(8'h81, 8'hff);
        br(8'h84, 8'h00);
        $display("test locked writes done");
        blkw('{8'h35, 8'h5a, 8'h3c, 8'he0});
        bw(8'h05, 8'hff);
        br(8'h05, 8'h00);
        blkr('{8'h35, 8'h5a, 8'h3c, 8'he0});
        `CHK({pci_drive_strength, combo_clk_drive_strength}, 2'b11)
        look(7'b0010000);
        $display("test unlocked writes done");
        bw(8'h80, 8'h34);
        blkw('{8'h35, 8'h00, 8'h00, 8'h00});
        blkr('{8'h35, 8'h5a, 8'h3c, 8'he0});
        $display("test relock done");
        blkw('{8'hb5, 8'h5a, 8'h3c, 8'he0});
        blkw('{8'h00, 8'hff, 8'hfe, 8'h07});
        bw(8'h82, 8'hff);
        blkr('{8'hb5, 8'h5a, 8'h3c, 8'he0});
        `CHK(fsel, 4'ha)
        $display("test write lock done");
        @(posedge clock);
        ce <= 1'b0;
        host.get(v, ok);
        `CHK(ok, 1'b0)
        @(posedge clock);
        ce <= 1'b1;
        $display("test clock enable done");
        final_report();
    end
endmodule

`default_nettype wire
